/* File: hdl/tape_buffer_threshold_control.sv */
// Flow control around the tape data buffer: motion and reconnect thresholds.
// Assumes the SCSI phase logic reports arbitration results and byte moves.
// Threshold values arrive as levels from the mode-setting logic outside.
// Functional notes
// RULE1: Start/stop write: hold tape motion until buffered data reaches motion threshold.
// RULE2: Start/stop read: fill from tape only when free space reaches motion threshold.
// RULE3: Motion threshold counts in 4-KByte buffer blocks.
// RULE4: Streaming write disconnect: reconnect once free space reaches reconnect threshold.
// RULE5: Streaming read disconnect: reconnect once buffered data reaches reconnect threshold.
// RULE6: Reconnect threshold counts in 4-KByte blocks, independent of motion threshold.
// RULE7: Reconnect needs a won arbitration, then reselects the former initiator.
// RULE8: Releasing a bus signal means not driving it, not driving false.
// RULE9: Disconnect releases the bus so it becomes free.
// RULE10: Keep byte occupancy and compare it or free space every cycle.
`timescale 1ns/1ps
`default_nettype none
module tape_buffer_threshold_control #(
    parameter int CNT_W = tape_buffer_pkg::CNT_W,
    parameter int THR_W = tape_buffer_pkg::THR_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [1:0] opMode,
    input wire logic [THR_W-1:0] motionThr,
    input wire logic [THR_W-1:0] reconnThr,
    input wire logic hostByteIn,
    input wire logic hostByteOut,
    input wire logic tapeByteIn,
    input wire logic tapeByteOut,
    input wire logic disconnectReq,
    input wire logic arbWon,
    input wire logic arbLost,
    input wire logic reselectDone,
    output logic tapeMotion,
    output logic hostXferEn,
    output logic arbReq,
    output logic reselReq,
    output logic busyOut,
    output logic busyOe,
    output logic [CNT_W-1:0] occupancy
);
    logic [CNT_W-1:0] freeSpace;
    logic [CNT_W-1:0] motionAmt;
    logic [CNT_W-1:0] reconnAmt;
    logic motionReached;
    logic reconnReached;
    logic incr;
    logic decr;
    tape_buffer_pkg::rc_state_t rcState_q;
    tape_buffer_pkg::op_mode_t mode;
    logic bufEmpty;
    logic bufFull;
    logic inConn;
    logic inArb;

    assign mode = tape_buffer_pkg::op_mode_t'(opMode);
    assign freeSpace = CNT_W'(tape_buffer_pkg::BUF_SIZE) - occupancy; // RULE10

    // Write flows fill the buffer from the host; read flows fill it from tape.
    assign incr = hostByteIn | tapeByteIn;
    assign decr = hostByteOut | tapeByteOut;

    // Saturation flags keep a stray pulse from wrapping the count.
    assign bufEmpty = (occupancy == '0);
    assign bufFull = (occupancy == CNT_W'(tape_buffer_pkg::BUF_SIZE));

    // Decoded states feed the registered bus outputs.
    assign inConn = (rcState_q == tape_buffer_pkg::RC_CONN);
    assign inArb = (rcState_q == tape_buffer_pkg::RC_ARB);

    // Each threshold looks at one quantity per mode; the other keeps a harmless default.
    always_comb
    begin
        motionAmt = occupancy;
        reconnAmt = freeSpace;
        case (mode)
            tape_buffer_pkg::MODE_SS_WRITE: motionAmt = occupancy; // RULE1
            tape_buffer_pkg::MODE_SS_READ: motionAmt = freeSpace; // RULE2
            tape_buffer_pkg::MODE_STREAM_WRITE: reconnAmt = freeSpace; // RULE4
            tape_buffer_pkg::MODE_STREAM_READ: reconnAmt = occupancy; // RULE5
            default: motionAmt = occupancy;
        endcase
    end

    threshold_compare #(.CNT_W(CNT_W), .THR_W(THR_W)) motionCmp (
        .amount(motionAmt),
        .thrSteps(motionThr),
        .reached(motionReached)
    ); // RULE3

    threshold_compare #(.CNT_W(CNT_W), .THR_W(THR_W)) reconnCmp (
        .amount(reconnAmt),
        .thrSteps(reconnThr),
        .reached(reconnReached)
    ); // RULE6

    // Simultaneous fill and drain leave the count unchanged.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            occupancy <= tape_buffer_pkg::CNT_RESET;
        else if (clkEn)
        begin
            if (incr && !decr && !bufFull)
                occupancy <= occupancy + CNT_W'(1); // RULE10
            else if (decr && !incr && !bufEmpty)
                occupancy <= occupancy - CNT_W'(1); // RULE10
        end
    end

    // Motion starts once the threshold is met and runs until the buffer
    // empties on write or fills on read, so the transport does not shuttle.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tapeMotion <= 1'b0;
        else if (clkEn)
        begin
            if (mode == tape_buffer_pkg::MODE_SS_WRITE)
            begin
                if (!tapeMotion && motionReached && !bufEmpty)
                    tapeMotion <= 1'b1; // RULE1
                else if (bufEmpty)
                    tapeMotion <= 1'b0;
            end
            else if (mode == tape_buffer_pkg::MODE_SS_READ)
            begin
                if (!tapeMotion && motionReached && !bufFull)
                    tapeMotion <= 1'b1; // RULE2
                else if (bufFull)
                    tapeMotion <= 1'b0;
            end
            // Streaming modes let the transport run; reconnection governs flow.
            else
                tapeMotion <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rcState_q <= tape_buffer_pkg::RC_IDLE;
        else if (clkEn)
        begin
            case (rcState_q)
                // Leaving reset the target is taken as already selected.
                tape_buffer_pkg::RC_IDLE:
                begin
                    rcState_q <= tape_buffer_pkg::RC_CONN;
                end
                tape_buffer_pkg::RC_CONN:
                begin
                    if (disconnectReq)
                        rcState_q <= tape_buffer_pkg::RC_DISC; // RULE9
                end
                tape_buffer_pkg::RC_DISC:
                begin
                    if (reconnReached)
                        rcState_q <= tape_buffer_pkg::RC_ARB; // RULE4 RULE5
                end
                // A lost arbitration waits again, so the threshold is rechecked first.
                tape_buffer_pkg::RC_ARB:
                begin
                    if (arbWon && reselectDone)
                        rcState_q <= tape_buffer_pkg::RC_CONN; // RULE7
                    else if (arbLost)
                        rcState_q <= tape_buffer_pkg::RC_DISC;
                end
                default:
                begin
                    rcState_q <= tape_buffer_pkg::RC_IDLE;
                end
            endcase
        end
    end

    // The request drops in the cycle the win is seen, so it never outlives it.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            arbReq <= 1'b0;
        else if (clkEn)
            arbReq <= inArb && !arbWon; // RULE7
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            reselReq <= 1'b0;
        else if (clkEn)
            reselReq <= inArb && arbWon; // RULE7
    end

    // Bus-facing outputs are registered from the state; in the disconnected
    // state BSY is released by dropping the enable, never driven false.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            busyOut <= 1'b0;
        else if (clkEn)
            busyOut <= inConn; // RULE8
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            busyOe <= 1'b0;
        else if (clkEn)
            busyOe <= inConn; // RULE8 RULE9
    end

    // Transfers stop in the cycle a disconnect is asked for, ahead of the release.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            hostXferEn <= 1'b0;
        else if (clkEn)
            hostXferEn <= inConn && !disconnectReq;
    end
endmodule
`default_nettype wire

/* File: hdl/tape_buffer_pkg.sv */
// Constants for the tape buffer threshold control block.
// Assumes a 21-bit byte occupancy count and thresholds given in 4-KByte steps.
package tape_buffer_pkg;
    localparam int BUF_BYTES = 1048576;
    localparam int CNT_W = 21;
    localparam int STEP_SHIFT = 12;
    localparam int THR_W = 8;
    localparam logic [20:0] CNT_RESET = 21'h000000;
    localparam logic [20:0] BUF_SIZE = 21'h100000;

    typedef enum logic [1:0]
    {
        MODE_SS_WRITE,
        MODE_SS_READ,
        MODE_STREAM_WRITE,
        MODE_STREAM_READ
    } op_mode_t;

    typedef enum
    {
        RC_IDLE,
        RC_DISC,
        RC_ARB,
        RC_CONN
    } rc_state_t;
endpackage

/* File: hdl/threshold_compare.sv */
// One threshold comparator: amount versus threshold steps of 4 KBytes.
// Assumes amount and threshold are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module threshold_compare #(
    parameter int CNT_W = 21,
    parameter int THR_W = 8
) (
    input wire logic [CNT_W-1:0] amount,
    input wire logic [THR_W-1:0] thrSteps,
    output logic reached
);
    logic [CNT_W-1:0] thrBytes;

    assign thrBytes = CNT_W'(thrSteps) << tape_buffer_pkg::STEP_SHIFT; // RULE3
    assign reached = (amount >= thrBytes); // RULE10
endmodule
`default_nettype wire

/* File: tb/tape_buffer_threshold_control_monitor.sv */
// Port checker for the tape buffer threshold control block.
// Assumes one clock domain and thresholds in 4096-byte steps.
`timescale 1ns/1ps
`default_nettype none
module tape_buffer_threshold_control_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [1:0] opMode,
    input wire logic [7:0] motionThr,
    input wire logic [7:0] reconnThr,
    input wire logic disconnectReq,
    input wire logic arbWon,
    input wire logic tapeMotion,
    input wire logic hostXferEn,
    input wire logic arbReq,
    input wire logic reselReq,
    input wire logic busyOe,
    input wire logic [20:0] occupancy
);
    localparam logic [20:0] FULL = tape_buffer_pkg::BUF_SIZE;
    logic [20:0] mB;
    logic [20:0] rB;
    assign mB = {1'b0, motionThr, 12'h000};
    assign rB = {1'b0, reconnThr, 12'h000};
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_freeze_hold: assert property (!clkEn |=> $stable(occupancy))
        else $error("count moved while frozen");
    chk_write_wait: assert property (opMode == 2'h0 && occupancy < mB && !tapeMotion
        |=> !tapeMotion) else $error("early write motion");
    chk_read_wait: assert property (opMode == 2'h1 && FULL - occupancy < mB && !tapeMotion
        |=> !tapeMotion) else $error("early read motion");
    chk_write_go: assert property (clkEn && opMode == 2'h0 && occupancy >= mB
        && occupancy != 21'h0 |=> tapeMotion) else $error("write motion late");
    chk_disc_release: assert property (clkEn && disconnectReq && busyOe
        |-> ##[1:2] !busyOe && !hostXferEn) else $error("bus kept");
    chk_resel_won: assert property ($rose(reselReq) |-> $past(arbWon))
        else $error("reselect without win");
    chk_arb_free: assert property (arbReq |-> !busyOe && !hostXferEn)
        else $error("arbitrating while connected");
    chk_rd_reconn: assert property ($rose(arbReq) && opMode == 2'h3
        |-> $past(occupancy) >= rB) else $error("early read reconnect");
    chk_wr_reconn: assert property ($rose(arbReq) && opMode == 2'h2
        |-> FULL - $past(occupancy) >= rB) else $error("early write reconnect");
    cover property ($rose(tapeMotion));
    cover property ($rose(reselReq));
    cover property ($fell(busyOe));
endmodule
bind tape_buffer_threshold_control tape_buffer_threshold_control_monitor u_mon (
    .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .opMode(opMode), .motionThr(motionThr),
    .reconnThr(reconnThr), .disconnectReq(disconnectReq), .arbWon(arbWon),
    .tapeMotion(tapeMotion), .hostXferEn(hostXferEn), .arbReq(arbReq),
    .reselReq(reselReq), .busyOe(busyOe), .occupancy(occupancy));
`default_nettype wire

/* File: tb/tape_host_model.sv */
// Initiator side model: grants or refuses arbitration after a wait.
// Assumes arbReq stands until it is answered.
`timescale 1ns/1ps
`default_nettype none
module tape_host_model (
    input wire logic mclk,
    input wire logic arbReq,
    input wire logic lose,
    input wire logic slow,
    output logic arbWon,
    output logic arbLost,
    output logic reselectDone
);
    logic [4:0] waitQ = 5'h00;
    always_ff @(posedge mclk)
        waitQ <= arbReq ? waitQ + 5'h01 : 5'h00;
    // A slow grant keeps the request standing long enough to be seen.
    assign arbWon = arbReq && waitQ >= (slow ? 5'h10 : 5'h01) && !lose;
    assign arbLost = arbReq && waitQ >= 5'h01 && lose;
    assign reselectDone = arbWon;
endmodule
`default_nettype wire

/* File: tb/tape_buffer_threshold_control_test.sv */
// Self-checking bench for the tape buffer threshold control block.
// Assumes the host model answers arbitration on the far side.
`timescale 1ns/1ps
`default_nettype none
module tape_buffer_threshold_control_test;
    logic mclk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, disc = 1'b0, lose = 1'b1, slow = 1'b1;
    logic [1:0] opMode = 2'h0;
    logic [7:0] motionThr = 8'h01, reconnThr = 8'h01;
    logic [3:0] pulse = 4'h0;
    logic won, lost, done, motion, xferEn, arbReq, busyOe, busyDrv;
    logic [20:0] occ;
    logic [31:0] seed = 32'h45;
    int miscompares = 0, samples_checked = 0;
    initial forever #50 mclk = ~mclk;
    tape_buffer_threshold_control u_tape_buffer_threshold_control (.mclk(mclk), .rst_n(rst_n),
        .clkEn(clkEn), .opMode(opMode), .motionThr(motionThr), .reconnThr(reconnThr),
        .hostByteIn(pulse[0]), .hostByteOut(pulse[1]), .tapeByteIn(pulse[2]),
        .tapeByteOut(pulse[3]), .disconnectReq(disc), .arbWon(won), .arbLost(lost),
        .reselectDone(done), .tapeMotion(motion), .hostXferEn(xferEn), .arbReq(arbReq),
        .reselReq(), .busyOut(busyDrv), .busyOe(busyOe), .occupancy(occ));
    tape_host_model u_tape_host_model (.mclk(mclk), .arbReq(arbReq), .lose(lose),
        .slow(slow), .arbWon(won), .arbLost(lost), .reselectDone(done));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [20:0] expBytes(input logic [7:0] steps);
        return {1'b0, steps, 12'h000};
    endfunction
    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Random gaps between byte pulses exercise the count at uneven rates.
    task automatic pulses(input int line, input int n);
        while (n > 0)
        begin
            @(posedge mclk);
            seed = xs(seed);
            pulse <= seed[0] ? 4'(1 << line) : 4'h0;
            n -= int'(seed[0]);
        end
        @(posedge mclk);
        pulse <= 4'h0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic dropLink();
        @(posedge mclk);
        disc <= 1'b1;
        @(posedge mclk);
        disc <= 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic waitOe();
        for (int i = 0; i < 400 && busyOe !== 1'b1; i++)
            @(negedge mclk);
    endtask
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        pulses(0, 4095);
        check(motion, 21'h0);
        pulses(0, 1);
        check(motion, 21'h1);
        check(occ, expBytes(motionThr));
        pulses(3, 4096);
        check(motion, 21'h0);
        @(posedge mclk);
        clkEn <= 1'b0;
        pulse <= 4'h1;
        opMode <= 2'h1;
        motionThr <= 8'hff;
        pulses(0, 0);
        check(occ, 21'h0);
        check(motion, 21'h0);
        @(posedge mclk);
        clkEn <= 1'b1;
        repeat (3) @(negedge mclk);
        check(motion, 21'h1);
        @(posedge mclk);
        opMode <= 2'h3;
        dropLink();
        check({xferEn, busyOe, busyDrv}, 21'h0);
        pulses(2, 4096);
        repeat (10) @(posedge mclk);
        lose <= 1'b0;
        waitOe();
        check(occ, 21'h1000);
        check(busyOe, 21'h1);
        check(busyDrv, 21'h1);
        @(posedge mclk);
        opMode <= 2'h2;
        reconnThr <= 8'hff;
        slow <= 1'b0;
        pulses(0, 1);
        dropLink();
        repeat (20) @(negedge mclk);
        check(arbReq, 21'h0);
        pulses(3, 1);
        waitOe();
        check(busyOe, 21'h1);
        close_out();
    end
    initial
    begin
        #6000000;
        miscompares++;
        close_out();
    end
endmodule
`default_nettype wire
